/* verilog/mpu_control_fault_status.sv */
// protection unit control, fault status/address and attribute lookup
`timescale 1ns/100ps

module mpu_control_fault_status (
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busPriv,
  input wire logic busSecure,
  input wire logic busDebug,
  output logic [31:0] busRdData,
  output logic busErr,
  // violation pulses from the access checker
  input wire logic dataViol,
  input wire logic fetchViolExec,
  input wire logic pushFault,
  input wire logic popFault,
  input wire logic lazyFault,
  input wire logic [31:0] faultAddr,
  input wire logic faultSecure,
  // bus-fault address valid per state, index 1 secure
  input wire logic [1:0] busFaultAddrValid,
  input wire logic [1:0] regionAnyEn,
  // attribute lookup
  input wire logic [2:0] attrIdx,
  input wire logic attrSecure,
  // per-state controls to the checker, index 1 secure
  output logic [1:0] protEn,
  output logic [1:0] bgMapEn,
  output logic [1:0] negPrioChkEn,
  output logic [1:0] defaultMapAll,
  output logic [1:0] privOnlyExec,
  output logic [1:0] faultAddrValid,
  // decoded attributes of the selected byte
  output mcf_pkg::mcf_kind_type attrOuterKind,
  output mcf_pkg::mcf_kind_type attrInnerKind,
  output logic [1:0] attrOuterAlloc,
  output logic [1:0] attrInnerAlloc,
  output logic attrIsDevice,
  output mcf_pkg::mcf_dev_type attrDevClass,
  output logic attrResvErr
);

  typedef enum logic [2:0] {
    SEL_NONE, SEL_FSR, SEL_FAR, SEL_CTRL, SEL_ATTR0, SEL_ATTR1
  } mcf_sel_type;
  // word address to register, used for both the primary and alias view
  function automatic mcf_sel_type mcf_sel(input logic [31:0] wordAddr);
    mcf_sel_type s;
    s = SEL_NONE;
    case (wordAddr)
      mcf_pkg::FSR_ADDR: s = SEL_FSR;
      mcf_pkg::FAR_ADDR: s = SEL_FAR;
      mcf_pkg::CTRL_ADDR: s = SEL_CTRL;
      mcf_pkg::ATTR0_ADDR: s = SEL_ATTR0;
      mcf_pkg::ATTR1_ADDR: s = SEL_ATTR1;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction
  // banked state, index 0 non-secure, 1 secure
  logic [mcf_pkg::CTRL_W-1:0] ctrl_ff [2];
  logic [7:0] fsr_ff [2];
  logic [31:0] far_ff [2];
  logic [mcf_pkg::CTRL_W-1:0] nxt_ctrl [2];
  logic [7:0] nxt_fsr [2];
  logic [31:0] nxt_far [2];
  logic [7:0] fsrSet [2];
  logic [7:0] fsrClr [2];
  // access decode
  logic [31:0] wordAddr;
  mcf_sel_type selPrim;
  mcf_sel_type selAlias;
  mcf_sel_type sel;
  logic bank;
  logic razWi;
  logic privFault;
  logic wrHit;
  logic rdHit;
  // bus answer
  logic [31:0] busRdData_ff;
  logic busErr_ff;
  logic [31:0] nxt_busRdData;
  logic nxt_busErr;
  // attribute tables
  logic [31:0] attrWord0 [2];
  logic [31:0] attrWord1 [2];
  logic [7:0] attrByteBank [2];
  logic [7:0] attrByteSel;
  // registered control outputs
  logic [1:0] protEn_ff;
  logic [1:0] bgMapEn_ff;
  logic [1:0] negPrioChkEn_ff;
  logic [1:0] defaultMapAll_ff;
  logic [1:0] privOnlyExec_ff;
  logic [1:0] faultAddrValid_ff;
  logic [1:0] nxt_protEn;
  logic [1:0] nxt_bgMapEn;
  logic [1:0] nxt_negPrioChkEn;
  logic [1:0] nxt_defaultMapAll;
  logic [1:0] nxt_privOnlyExec;
  logic [1:0] nxt_faultAddrValid;
  // registered attribute outputs
  mcf_pkg::mcf_kind_type decOuterKind;
  mcf_pkg::mcf_kind_type decInnerKind;
  logic [1:0] decOuterAlloc;
  logic [1:0] decInnerAlloc;
  logic decIsDevice;
  mcf_pkg::mcf_dev_type decDevClass;
  logic decResvErr;
  mcf_pkg::mcf_kind_type attrOuterKind_ff;
  mcf_pkg::mcf_kind_type attrInnerKind_ff;
  logic [1:0] attrOuterAlloc_ff;
  logic [1:0] attrInnerAlloc_ff;
  logic attrIsDevice_ff;
  mcf_pkg::mcf_dev_type attrDevClass_ff;
  logic attrResvErr_ff;
  // byte lanes dropped: status takes any width, narrow control writes act as word
  always_comb
  begin
    wordAddr = {busAddr[31:2], 2'b00};
    selPrim = mcf_sel(wordAddr);
    selAlias = mcf_sel(wordAddr - mcf_pkg::NS_ALIAS_OFS);
    sel = SEL_NONE;
    bank = busSecure;
    razWi = 1'b0;
    if (selPrim != SEL_NONE)
      sel = selPrim;
    else if (selAlias != SEL_NONE)
    begin
      // alias reaches the non-secure copy, secure software only
      sel = selAlias;
      bank = 1'b0;
      razWi = !busSecure || busDebug;
    end
    // debugger counts as privileged
    privFault = (sel != SEL_NONE) && !busPriv && !busDebug;
    wrHit = busWrite && (sel != SEL_NONE) && !privFault && !razWi;
    rdHit = busRead && (sel != SEL_NONE) && !privFault && !razWi;
  end

  // banked state update; a fault in the same cycle as a clear wins
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      nxt_ctrl[b] = ctrl_ff[b];
      nxt_far[b] = far_ff[b];
      fsrSet[b] = 8'h00;
      fsrClr[b] = 8'h00;
      if (wrHit && bank == b[0])
      begin
        if (sel == SEL_CTRL)
          nxt_ctrl[b] = busWrData[mcf_pkg::CTRL_W-1:0];
        if (sel == SEL_FSR)
          fsrClr[b] = busWrData[7:0] & mcf_pkg::FSR_IMPL_MASK;
        if (sel == SEL_FAR)
          nxt_far[b] = busWrData;
      end
      // checker pulses land in the bank of the faulting state
      if (faultSecure == b[0])
      begin
        fsrSet[b][mcf_pkg::FSR_LAZY_BIT] = lazyFault;
        fsrSet[b][mcf_pkg::FSR_PUSH_BIT] = pushFault;
        fsrSet[b][mcf_pkg::FSR_POP_BIT] = popFault;
        fsrSet[b][mcf_pkg::FSR_FETCH_BIT] = fetchViolExec;
        if (dataViol)
        begin
          fsrSet[b][mcf_pkg::FSR_DATA_BIT] = 1'b1;
          fsrSet[b][mcf_pkg::FSR_VALID_BIT] = 1'b1;
          nxt_far[b] = faultAddr;
        end
      end
      nxt_fsr[b] = ((fsr_ff[b] & ~fsrClr[b]) | fsrSet[b]) & mcf_pkg::FSR_IMPL_MASK;
    end
  end
  // warm reset clears flags and control
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int b = 0; b < 2; b++)
      begin
        ctrl_ff[b] <= mcf_pkg::CTRL_RST;
        fsr_ff[b] <= mcf_pkg::FSR_RST;
        far_ff[b] <= mcf_pkg::FAR_RST;
      end
    end
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        ctrl_ff[b] <= nxt_ctrl[b];
        fsr_ff[b] <= nxt_fsr[b];
        far_ff[b] <= nxt_far[b];
      end
    end
  end

  // one attribute table per security state
  for (genvar g = 0; g < 2; g++)
  begin : gBank
    mcf_attr_table uTable (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wrEn(wrHit && bank == 1'(g) && (sel == SEL_ATTR0 || sel == SEL_ATTR1)),
      .wrHigh(sel == SEL_ATTR1),
      .wrData(busWrData),
      .attrIdx(attrIdx),
      .word0(attrWord0[g]),
      .word1(attrWord1[g]),
      .attrByte(attrByteBank[g])
    );
  end

  // answer one cycle after the strobe; unmapped and refused alias reads give zero
  always_comb
  begin
    nxt_busRdData = 32'h00000000;
    nxt_busErr = (busRead || busWrite) && privFault;
    if (rdHit)
    begin
      case (sel)
        SEL_FSR: nxt_busRdData = {24'h000000, fsr_ff[bank]};
        // shared address register: hidden while a bus fault owns it
        SEL_FAR: nxt_busRdData = busFaultAddrValid[bank] ? 32'h00000000 : far_ff[bank];
        SEL_CTRL: nxt_busRdData = {29'h00000000, ctrl_ff[bank]};
        SEL_ATTR0: nxt_busRdData = attrWord0[bank];
        SEL_ATTR1: nxt_busRdData = attrWord1[bank];
        default: nxt_busRdData = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busRdData_ff <= 32'h00000000;
      busErr_ff <= 1'b0;
    end
    else
    begin
      busRdData_ff <= nxt_busRdData;
      busErr_ff <= nxt_busErr;
    end
  end

  // controls taken from next state so outputs track the register without lag
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      nxt_protEn[b] = nxt_ctrl[b][mcf_pkg::CTRL_EN_BIT];
      nxt_defaultMapAll[b] = !nxt_ctrl[b][mcf_pkg::CTRL_EN_BIT];
      nxt_bgMapEn[b] = nxt_ctrl[b][mcf_pkg::CTRL_EN_BIT] &
        nxt_ctrl[b][mcf_pkg::CTRL_BG_BIT];
      // masked so a stray set while disabled stays harmless
      nxt_negPrioChkEn[b] = nxt_ctrl[b][mcf_pkg::CTRL_EN_BIT] &
        nxt_ctrl[b][mcf_pkg::CTRL_NEG_BIT];
      nxt_privOnlyExec[b] = nxt_bgMapEn[b] & !regionAnyEn[b];
      nxt_faultAddrValid[b] = nxt_fsr[b][mcf_pkg::FSR_VALID_BIT];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protEn_ff <= 2'h0;
      bgMapEn_ff <= 2'h0;
      negPrioChkEn_ff <= 2'h0;
      defaultMapAll_ff <= 2'h3;
      privOnlyExec_ff <= 2'h0;
      faultAddrValid_ff <= 2'h0;
    end
    else
    begin
      protEn_ff <= nxt_protEn;
      bgMapEn_ff <= nxt_bgMapEn;
      negPrioChkEn_ff <= nxt_negPrioChkEn;
      defaultMapAll_ff <= nxt_defaultMapAll;
      privOnlyExec_ff <= nxt_privOnlyExec;
      faultAddrValid_ff <= nxt_faultAddrValid;
    end
  end

  // attribute lookup: byte from the requested state, decoded then registered
  assign attrByteSel = attrByteBank[attrSecure];
  mcf_attr_decode uDecode (
    .attrByte(attrByteSel),
    .outerKind(decOuterKind),
    .innerKind(decInnerKind),
    .outerAlloc(decOuterAlloc),
    .innerAlloc(decInnerAlloc),
    .isDevice(decIsDevice),
    .devClass(decDevClass),
    .resvErr(decResvErr)
  );
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      attrOuterKind_ff <= mcf_pkg::MK_DEVICE;
      attrInnerKind_ff <= mcf_pkg::MK_DEVICE;
      attrOuterAlloc_ff <= 2'h0;
      attrInnerAlloc_ff <= 2'h0;
      attrIsDevice_ff <= 1'b1;
      attrDevClass_ff <= mcf_pkg::DV_STRICT;
      attrResvErr_ff <= 1'b0;
    end
    else
    begin
      attrOuterKind_ff <= decOuterKind;
      attrInnerKind_ff <= decInnerKind;
      attrOuterAlloc_ff <= decOuterAlloc;
      attrInnerAlloc_ff <= decInnerAlloc;
      attrIsDevice_ff <= decIsDevice;
      attrDevClass_ff <= decDevClass;
      attrResvErr_ff <= decResvErr;
    end
  end

  // every output straight from a flop
  assign busRdData = busRdData_ff;
  assign busErr = busErr_ff;
  assign protEn = protEn_ff;
  assign bgMapEn = bgMapEn_ff;
  assign negPrioChkEn = negPrioChkEn_ff;
  assign defaultMapAll = defaultMapAll_ff;
  assign privOnlyExec = privOnlyExec_ff;
  assign faultAddrValid = faultAddrValid_ff;
  assign attrOuterKind = attrOuterKind_ff;
  assign attrInnerKind = attrInnerKind_ff;
  assign attrOuterAlloc = attrOuterAlloc_ff;
  assign attrInnerAlloc = attrInnerAlloc_ff;
  assign attrIsDevice = attrIsDevice_ff;
  assign attrDevClass = attrDevClass_ff;
  assign attrResvErr = attrResvErr_ff;

endmodule

/* verilog/mcf_pkg.sv */
// shared constants, types and decode helpers for the protection control block
package mcf_pkg;

  // primary register addresses, one aligned word each
  localparam logic [31:0] FSR_ADDR = 32'hE000ED28;
  localparam logic [31:0] FAR_ADDR = 32'hE000ED34;
  localparam logic [31:0] CTRL_ADDR = 32'hE000ED94;
  localparam logic [31:0] ATTR0_ADDR = 32'hE000EDC0;
  localparam logic [31:0] ATTR1_ADDR = 32'hE000EDC4;
  // non-secure alias view sits this far above the primary view
  localparam logic [31:0] NS_ALIAS_OFS = 32'h00020000;

  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NEG_BIT = 1;
  localparam int CTRL_BG_BIT = 2;
  localparam int CTRL_W = 3;

  // fault status field positions
  localparam int FSR_VALID_BIT = 7;
  localparam int FSR_LAZY_BIT = 5;
  localparam int FSR_PUSH_BIT = 4;
  localparam int FSR_POP_BIT = 3;
  localparam int FSR_DATA_BIT = 1;
  localparam int FSR_FETCH_BIT = 0;
  // bits 6 and 2 never hold state
  localparam logic [7:0] FSR_IMPL_MASK = 8'hBB;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [7:0] FSR_RST = 8'h00;
  localparam logic [31:0] FAR_RST = 32'h00000000;
  localparam logic [31:0] ATTR_RST = 32'h00000000;

  // attribute byte encodings
  localparam logic [3:0] OUTER_DEVICE = 4'h0;
  localparam logic [3:0] LEVEL_NONCACHE = 4'h4;
  localparam logic [1:0] ALLOC_NONE = 2'h0;

  typedef enum logic [2:0] {
    MK_DEVICE, MK_NONCACHE, MK_WT_TRANS, MK_WB_TRANS,
    MK_WT_NONTRANS, MK_WB_NONTRANS, MK_UNPRED
  } mcf_kind_type;

  typedef enum logic [1:0] {DV_STRICT, DV_EARLY_ACK, DV_REORDER, DV_RELAXED} mcf_dev_type;

  // one cache level nibble, outer or inner, same encoding for both
  function automatic mcf_kind_type mcf_level_kind(input logic [3:0] lvl);
    mcf_kind_type k;
    k = MK_UNPRED;
    case (lvl[3:2])
      2'h0: k = (lvl[1:0] == ALLOC_NONE) ? MK_UNPRED : MK_WT_TRANS;
      2'h1: k = (lvl == LEVEL_NONCACHE) ? MK_NONCACHE : MK_WB_TRANS;
      2'h2: k = MK_WT_NONTRANS;
      default: k = MK_WB_NONTRANS;
    endcase
    return k;
  endfunction

endpackage

/* verilog/mcf_attr_decode.sv */
// decoder for one memory attribute byte
`timescale 1ns/100ps
module mcf_attr_decode (
  input wire logic [7:0] attrByte,
  output mcf_pkg::mcf_kind_type outerKind,
  output mcf_pkg::mcf_kind_type innerKind,
  output logic [1:0] outerAlloc,
  output logic [1:0] innerAlloc,
  output logic isDevice,
  output mcf_pkg::mcf_dev_type devClass,
  output logic resvErr
);

  // zero top nibble means device memory
  assign isDevice = (attrByte[7:4] == mcf_pkg::OUTER_DEVICE);
  // ordering class only means something for device memory
  assign devClass = isDevice ? mcf_pkg::mcf_dev_type'(attrByte[3:2]) : mcf_pkg::DV_STRICT;
  assign outerKind = isDevice ? mcf_pkg::MK_DEVICE : mcf_pkg::mcf_level_kind(attrByte[7:4]);
  // inner zero comes back as unpredictable, with no allocate hints and no error flag
  assign innerKind = isDevice ? mcf_pkg::MK_DEVICE : mcf_pkg::mcf_level_kind(attrByte[3:0]);
  // low bits are read/write allocate hints, except the non-cacheable pattern
  assign outerAlloc = (isDevice || outerKind == mcf_pkg::MK_NONCACHE) ?
    mcf_pkg::ALLOC_NONE : attrByte[5:4];
  assign innerAlloc = (isDevice || innerKind == mcf_pkg::MK_NONCACHE ||
    innerKind == mcf_pkg::MK_UNPRED) ? mcf_pkg::ALLOC_NONE : attrByte[1:0];
  // device low bits must be zero
  assign resvErr = isDevice && (attrByte[1:0] != mcf_pkg::ALLOC_NONE);

endmodule

/* verilog/mcf_attr_table.sv */
// pair of attribute indirection words for one security state
`timescale 1ns/100ps
module mcf_attr_table (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic wrHigh,
  input wire logic [31:0] wrData,
  input wire logic [2:0] attrIdx,
  output logic [31:0] word0,
  output logic [31:0] word1,
  output logic [7:0] attrByte
);

  logic [31:0] attr_ff [2];
  logic [31:0] nxt_attr [2];

  // write one of the two words
  always_comb
  begin
    nxt_attr[0] = attr_ff[0];
    nxt_attr[1] = attr_ff[1];
    if (wrEn)
      nxt_attr[wrHigh] = wrData;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      attr_ff[0] <= mcf_pkg::ATTR_RST;
      attr_ff[1] <= mcf_pkg::ATTR_RST;
    end
    else
    begin
      attr_ff[0] <= nxt_attr[0];
      attr_ff[1] <= nxt_attr[1];
    end
  end

  assign word0 = attr_ff[0];
  assign word1 = attr_ff[1];
  // index bit 2 picks the word, bits 1:0 the byte
  assign attrByte = attr_ff[attrIdx[2]][8*attrIdx[1:0] +: 8];

endmodule

/* test/mcf_assertions.sv */
// port checker for the protection control block
`timescale 1ns/100ps
module mcf_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busPriv,
  input wire logic busDebug,
  input wire logic [31:0] busRdData,
  input wire logic busErr,
  input wire logic dataViol,
  input wire logic faultSecure,
  input wire logic [1:0] regionAnyEn,
  input wire logic [1:0] protEn,
  input wire logic [1:0] bgMapEn,
  input wire logic [1:0] negPrioChkEn,
  input wire logic [1:0] defaultMapAll,
  input wire logic [1:0] privOnlyExec,
  input wire logic [1:0] faultAddrValid,
  input wire logic attrIsDevice,
  input mcf_pkg::mcf_kind_type attrOuterKind,
  input wire logic [1:0] attrOuterAlloc,
  input mcf_pkg::mcf_dev_type attrDevClass
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // core-side read of the control word without privilege
  sequence unprivRead;
    busRead && !busPriv && !busDebug && busAddr == mcf_pkg::CTRL_ADDR;
  endsequence
  sequence refusedAnswer;
    busErr && busRdData == 32'h0;
  endsequence
  unpriv_refused_a: assert property (unprivRead |=> refusedAnswer)
    else $error("unprivileged read not refused");
  err_cause_a: assert property (busErr |-> $past(busRead || busWrite) && !$past(busPriv || busDebug))
    else $error("bus fault without unprivileged access");
  rd_quiet_a: assert property (!$past(busRead) |-> busRdData == 32'h0)
    else $error("read data outside answer cycle");
  data_valid_a: assert property (dataViol && !faultSecure |=> faultAddrValid[0])
    else $error("data violation did not mark address valid");
  valid_hold_a: assert property (faultAddrValid[0] && !busWrite |=> faultAddrValid[0])
    else $error("valid flag dropped without a write");
  valid_rise_a: assert property ($rose(faultAddrValid[1]) |-> $past(dataViol && faultSecure))
    else $error("valid flag rose without data violation");
  map_default_a: assert property (defaultMapAll == ~protEn)
    else $error("default map does not follow enable");
  bg_masked_a: assert property (((bgMapEn | negPrioChkEn) & ~protEn) == 2'h0)
    else $error("control bit active while disabled");
  priv_only_a: assert property ($stable(bgMapEn) && $stable(regionAnyEn)
    |-> privOnlyExec == (bgMapEn & ~regionAnyEn))
    else $error("privileged-only execution wrong");
  dev_kind_a: assert property (attrIsDevice |-> attrOuterKind == mcf_pkg::MK_DEVICE
    && attrOuterAlloc == 2'h0)
    else $error("device byte decoded as normal");
  dev_class_a: assert property (!attrIsDevice |-> attrDevClass == mcf_pkg::DV_STRICT)
    else $error("ordering class on normal memory");
endmodule

bind mpu_control_fault_status mcf_assertions chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .busPriv(busPriv),
  .busDebug(busDebug), .busRdData(busRdData), .busErr(busErr), .dataViol(dataViol),
  .faultSecure(faultSecure), .regionAnyEn(regionAnyEn), .protEn(protEn), .bgMapEn(bgMapEn),
  .negPrioChkEn(negPrioChkEn), .defaultMapAll(defaultMapAll), .privOnlyExec(privOnlyExec),
  .faultAddrValid(faultAddrValid), .attrIsDevice(attrIsDevice),
  .attrOuterKind(attrOuterKind), .attrOuterAlloc(attrOuterAlloc),
  .attrDevClass(attrDevClass));

/* test/mcf_core_model.sv */
// behavioural core side raising fault pulses on request
`timescale 1ns/100ps
module mcf_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] req,
  input wire logic [31:0] reqAddr,
  input wire logic reqSecure,
  output logic dataViol,
  output logic fetchViolExec,
  output logic pushFault,
  output logic popFault,
  output logic lazyFault,
  output logic [31:0] faultAddr,
  output logic faultSecure
);
  // one pulse per request; code 6 is a fetch fault flushed unexecuted
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {dataViol, fetchViolExec, pushFault, popFault, lazyFault} <= 5'h00;
      faultAddr <= 32'h0;
      faultSecure <= 1'h0;
    end
    else
    begin
      dataViol <= (req == 3'h1);
      pushFault <= (req == 3'h2);
      popFault <= (req == 3'h3);
      lazyFault <= (req == 3'h4);
      fetchViolExec <= (req == 3'h5);
      faultSecure <= reqSecure;
      // address means nothing off the data pulse, so scramble it there
      faultAddr <= (req == 3'h1) ? reqAddr : ~faultAddr;
    end
  end
endmodule

/* test/tb_mpu_control_fault_status.sv */
// self-checking bench for the protection control block
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module tb_mpu_control_fault_status;
  logic clk_sys = 1'h0, rst_n = 1'h0;
  logic [31:0] busAddr = 32'h0, busWrData = 32'h0, reqAddr = 32'h0, busRdData, faultAddr;
  logic busWrite = 1'h0, busRead = 1'h0, busPriv = 1'h0, busSecure = 1'h0, busDebug = 1'h0;
  logic busErr, dataViol, fetchViolExec, pushFault, popFault, lazyFault, faultSecure;
  logic [1:0] busFaultAddrValid = 2'h0, regionAnyEn = 2'h0, protEn, bgMapEn, negPrioChkEn;
  logic [1:0] defaultMapAll, privOnlyExec, faultAddrValid, attrOuterAlloc, attrInnerAlloc;
  logic [2:0] attrIdx = 3'h0, req = 3'h0;
  logic attrSecure = 1'h1, reqSecure = 1'h0, attrIsDevice, attrResvErr;
  mcf_pkg::mcf_kind_type attrOuterKind, attrInnerKind;
  mcf_pkg::mcf_dev_type attrDevClass;
  int err_count = 0, num_checks = 0;
  localparam logic [31:0] CTRL = mcf_pkg::CTRL_ADDR, FSR = mcf_pkg::FSR_ADDR;
  localparam logic [31:0] FAR = mcf_pkg::FAR_ADDR, NS = mcf_pkg::NS_ALIAS_OFS;
  mcf_pkg::mcf_kind_type expO [3] = '{mcf_pkg::MK_NONCACHE, mcf_pkg::MK_WB_NONTRANS,
    mcf_pkg::MK_WT_NONTRANS};
  mcf_pkg::mcf_kind_type expI [3] = '{mcf_pkg::MK_NONCACHE, mcf_pkg::MK_WB_NONTRANS,
    mcf_pkg::MK_WB_TRANS};
  logic [1:0] expA [3] = '{2'h0, 2'h3, 2'h2};

  always #12.5 clk_sys = ~clk_sys;

  mpu_control_fault_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .busAddr(busAddr),
    .busWrData(busWrData), .busWrite(busWrite), .busRead(busRead), .busPriv(busPriv),
    .busSecure(busSecure), .busDebug(busDebug), .busRdData(busRdData), .busErr(busErr),
    .dataViol(dataViol), .fetchViolExec(fetchViolExec), .pushFault(pushFault),
    .popFault(popFault), .lazyFault(lazyFault), .faultAddr(faultAddr),
    .faultSecure(faultSecure), .busFaultAddrValid(busFaultAddrValid),
    .regionAnyEn(regionAnyEn),
    .attrIdx(attrIdx), .attrSecure(attrSecure), .protEn(protEn), .bgMapEn(bgMapEn),
    .negPrioChkEn(negPrioChkEn), .defaultMapAll(defaultMapAll), .privOnlyExec(privOnlyExec),
    .faultAddrValid(faultAddrValid), .attrOuterKind(attrOuterKind),
    .attrInnerKind(attrInnerKind), .attrOuterAlloc(attrOuterAlloc),
    .attrInnerAlloc(attrInnerAlloc), .attrIsDevice(attrIsDevice),
    .attrDevClass(attrDevClass), .attrResvErr(attrResvErr));

  mcf_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .reqAddr(reqAddr),
    .reqSecure(reqSecure), .dataViol(dataViol), .fetchViolExec(fetchViolExec),
    .pushFault(pushFault), .popFault(popFault), .lazyFault(lazyFault),
    .faultAddr(faultAddr), .faultSecure(faultSecure));

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one strobe cycle; answer is taken in the cycle after, where it stands
  task automatic bus(input logic w, input logic [31:0] a, d, input logic p, s, g,
    output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    busWrite <= w;
    busRead <= !w;
    busAddr <= a;
    busWrData <= d;
    busPriv <= p;
    busSecure <= s;
    busDebug <= g;
    @(posedge clk_sys);
    busWrite <= 1'h0;
    busRead <= 1'h0;
    #1;
    q = busRdData;
    e = busErr;
  endtask

  task automatic wr(input logic [31:0] a, d, input logic p = 1'h1, s = 1'h1, ee = 1'h0);
    logic [31:0] q;
    logic e;
    bus(1'h1, a, d, p, s, 1'h0, q, e);
    `CHK(e, ee)
  endtask

  task automatic rd(input logic [31:0] a, x, input logic p = 1'h1, s = 1'h1, ee = 1'h0,
    g = 1'h0);
    logic [31:0] q;
    logic e;
    bus(1'h0, a, 32'h0, p, s, g, q, e);
    `CHK(q, x)
    `CHK(e, ee)
  endtask

  // request one fault pulse from the core model
  task automatic fault(input logic [2:0] c, input logic sec);
    @(posedge clk_sys);
    req <= c;
    reqAddr <= 32'h20001234;
    reqSecure <= sec;
    @(posedge clk_sys);
    req <= 3'h0;
    tick(2);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(FSR, 32'h0);
    rd(CTRL, 32'h0);
    `CHK(defaultMapAll, 2'h3)
    // all ones: reserved bits drop, enable set together with neg-priority
    wr(CTRL, 32'hFFFFFFFF);
    rd(CTRL, 32'h7);
    `CHK(bgMapEn, 2'h2)
    `CHK(negPrioChkEn, 2'h2)
    `CHK(privOnlyExec, 2'h2)
    @(posedge clk_sys);
    regionAnyEn <= 2'h2;
    tick(2);
    `CHK(privOnlyExec, 2'h0)
    wr(CTRL, 32'h4);
    `CHK(bgMapEn, 2'h0)
    `CHK(defaultMapAll, 2'h3)
    // unprivileged accesses are refused and change nothing
    rd(CTRL, 32'h0, 1'h0, 1'h1, 1'h1);
    wr(CTRL, 32'h1, 1'h0, 1'h1, 1'h1);
    rd(CTRL, 32'h4);
    // alias view reaches the non-secure copy from secure state only
    wr(CTRL + NS, 32'h1);
    `CHK(protEn, 2'h1)
    rd(CTRL + NS, 32'h1);
    rd(CTRL, 32'h1, 1'h1, 1'h0);
    rd(CTRL + NS, 32'h0, 1'h1, 1'h0);
    rd(CTRL + NS, 32'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    wr(CTRL + NS, 32'h0, 1'h1, 1'h0);
    rd(CTRL, 32'h1, 1'h1, 1'h0);
    rd(32'hE000ED30, 32'h0);
    // data fault to the non-secure bank, derived faults to the secure bank
    fault(3'h1, 1'h0);
    `CHK(faultAddrValid, 2'h1)
    rd(FSR, 32'h82, 1'h1, 1'h0);
    rd(FAR, 32'h20001234, 1'h1, 1'h0);
    for (int i = 2; i < 7; i++)
      fault(3'(i), 1'h1);
    rd(FSR, 32'h39, 1'h1, 1'h1);
    // shared address register hidden while a bus-fault address is valid
    @(posedge clk_sys);
    busFaultAddrValid <= 2'h1;
    rd(FAR, 32'h0, 1'h1, 1'h0);
    @(posedge clk_sys);
    busFaultAddrValid <= 2'h0;
    wr(FSR, 32'h02, 1'h1, 1'h0);
    rd(FSR, 32'h80, 1'h1, 1'h0);
    wr(FSR, 32'h00, 1'h1, 1'h0);
    rd(FSR, 32'h80, 1'h1, 1'h0);
    rd(FAR, 32'h20001234, 1'h1, 1'h0);
    wr(FSR, 32'hFF, 1'h1, 1'h0);
    rd(FSR, 32'h0, 1'h1, 1'h0);
    // eight attribute bytes: four device classes, then normal and reserved
    wr(mcf_pkg::ATTR0_ADDR, 32'h0C080400);
    wr(mcf_pkg::ATTR1_ADDR, 32'h01A6FF44);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      attrIdx <= 3'(i);
      tick(2);
      `CHK(attrIsDevice, 1'(i < 4 || i == 7))
      `CHK(attrDevClass, mcf_pkg::mcf_dev_type'(i < 4 ? i : 0))
      `CHK(attrResvErr, 1'(i == 7))
      if (i > 3 && i < 7)
      begin
        `CHK(attrOuterKind, expO[i - 4])
        `CHK(attrInnerKind, expI[i - 4])
        `CHK(attrOuterAlloc, expA[i - 4])
        `CHK(attrInnerAlloc, expA[i - 4])
      end
    end
    // non-secure table was never written, so byte 7 there is plain device
    @(posedge clk_sys);
    attrSecure <= 1'h0;
    tick(2);
    `CHK(attrResvErr, 1'h0)
    `CHK(attrIsDevice, 1'h1)
    // warm reset in mid-run clears flags and control
    fault(3'h1, 1'h1);
    `CHK(faultAddrValid, 2'h2)
    @(posedge clk_sys);
    rst_n <= 1'h0;
    tick(2);
    @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(FSR, 32'h0);
    rd(CTRL, 32'h0);
    give_verdict();
  end
endmodule
